// ### cpu_ctl_defines.svh
// timing counts, field positions and instruction codes of the processor control block
`ifndef CPU_CTL_DEFINES_SVH
`define CPU_CTL_DEFINES_SVH

// ============================================================
// clock and derived timing
`define CLK_NS 100
`define TS_MIN_NS 200
`define TS_FAST_CYC ((`TS_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define TS_SLOW_CYC (`TS_FAST_CYC + 1)
`define TP_NS 100
`define TP_CYC ((`TP_NS + `CLK_NS - 1) / `CLK_NS)
`define RET_LAG_NS 50
`define RET_LAG_CYC ((`RET_LAG_NS + `CLK_NS - 1) / `CLK_NS)
`define SYSCLR_NS 600
`define SYSCLR_CYC ((`SYSCLR_NS + `CLK_NS - 1) / `CLK_NS)
`define CARRY_LOAD_NS 100

// ============================================================
// status word positions (printed bit n sits at index 11-n)
`define ST_LINK 11
`define ST_GT 10
`define ST_INTBUS 9
`define ST_NOINT 8
`define ST_INTEN 7
`define ST_PROT 6
`define ST_IF_HI 5
`define ST_IF_LO 3
`define ST_DF_HI 2
`define ST_DF_LO 0

// ============================================================
// instruction decode
`define OPC_ISZ 3'h2
`define OPC_JMS 3'h4
`define OPC_JMP 3'h5
`define OPC_IOT 3'h6
`define OPR_GROUP 4'hf
`define IOT_ION 12'hc01
`define IOT_IOF 12'hc02
`define IOT_CLEAR 12'hc07

`endif

// ### cpu_ctl_pkg.sv
// types shared by the processor control block and its time-state generator
`include "cpu_ctl_defines.svh"
package cpu_ctl_pkg;
    typedef enum logic [1:0] {
        FETCH = 2'b00,
        DEFER = 2'b01,
        EXECUTE = 2'b10
    } major_t;

    typedef enum logic [1:0] {
        PH_TS1 = 2'b00,
        PH_TS2 = 2'b01,
        PH_TS3 = 2'b10,
        PH_TS4 = 2'b11
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [1:0] cnt;
    } timer_t;

    typedef struct packed {
        logic run;
        logic [11:0] ma;
        logic [11:0] pc;
        logic [11:0] ir;
        logic [11:0] ac;
        logic [11:0] mq;
        major_t major;
        logic link;
        logic intEn;
        logic carryFF;
        logic keyGate;
        logic keyPrev;
        logic powerPrev;
        logic driveInh;
        logic [2:0] ib;
        logic [2:0] ifld;
        logic [2:0] df;
        logic [3:0] sysCnt;
        logic [1:0] retCnt;
    } ctl_t;
endpackage

// ### time_state_gen.sv
// time-state and time-pulse sequencer driven by the run flip-flop
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ctl_defines.svh"
module time_state_gen #(
    parameter int FAST_CYC = `TS_FAST_CYC,
    parameter int SLOW_CYC = `TS_SLOW_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic runEn,
    input wire logic slowCycle,
    // timing outputs
    output logic [3:0] timeState_n,
    output logic [3:0] timePulse,
    output logic idle
);
    import cpu_ctl_pkg::*;

    timer_t s, next_s;
    logic [1:0] last;

    // =========================================================
    // sequencing
    // a stopped machine parks at the start of time state one
    always_comb begin
        last = slowCycle ? 2'(SLOW_CYC - 1) : 2'(FAST_CYC - 1);
        next_s = s;
        if (!(s.phase == PH_TS1 && s.cnt == 2'h0 && !runEn)) begin
            if (s.cnt >= last) begin
                next_s.cnt = 2'h0;
                next_s.phase = phase_t'(s.phase + 2'h1);
            end else begin
                next_s.cnt = s.cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign idle = (s.phase == PH_TS1) && (s.cnt == 2'h0);

    // =========================================================
    // decode: pulse sits in the last cycle, state flips one cycle after it rises
    for (genvar k = 0; k < 4; k++) begin : g_dec
        assign timeState_n[k] = !(s.phase == phase_t'(k));
        assign timePulse[k] = (s.phase == phase_t'(k)) && (s.cnt >= last);
    end
endmodule
`default_nettype wire

// ### cpu_ctl.sv
// processor-side backplane control: memory timing, state lines, panel and clear logic
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ctl_defines.svh"
module cpu_ctl (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // cycle control
    input wire logic memStart_n,
    input wire logic slowCycle,
    input wire logic powerOk,
    input wire logic romAddrSel_n,
    // memory side
    input wire logic [11:0] memData,
    output logic memWrite,
    output logic driveCur,
    output logic returnCur,
    output logic inhibitDrive,
    output logic senseStrobe,
    // state and instruction lines
    output logic [2:0] opcodeLines_n,
    output logic fetchLine_n,
    output logic deferLine_n,
    output logic executeLine_n,
    input wire logic [2:0] majorBus_n,
    input wire logic stateRegDisconnect_n,
    output logic dmaState,
    output logic nextFetch,
    // carry bit
    input wire logic carryLoad_n,
    input wire logic carryIn_n,
    output logic carryLine_n,
    output logic carryOutLine_n,
    // front panel
    input wire logic fieldLoadKey,
    input wire logic examineKey,
    input wire logic depositKey,
    input wire logic haltKey,
    input wire logic singleStepKey,
    input wire logic clearKey,
    input wire logic panelAddrLoadPulse,
    input wire logic displaySelA,
    input wire logic displaySelB,
    input wire logic [11:0] switchReg,
    output logic keyGate_n,
    output logic haltRequest_n,
    output logic runLine_n,
    // data bus
    input wire logic [11:0] dataIn,
    output logic [11:0] dataOut,
    output logic dataOe_n,
    // status and system
    input wire logic greaterThanFlag,
    input wire logic intBus,
    input wire logic protectedMode_n,
    output logic intInhibit,
    output logic sysClear,
    // time states and pulses, index 0 is state one
    output logic [3:0] timeState_n,
    output logic [3:0] timePulse
);
    import cpu_ctl_pkg::*;

    ctl_t s, next_s;
    logic idle, cycOn, ramOn, disc, prot, haltReq, keyAny;
    logic [3:0] ts;
    logic [2:0] opc;
    logic isOpr2, isOpr3, switchRd, haltInstr;
    logic [11:0] effAddr, pcNext, statusWord;
    major_t nextMajor;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // =========================================================
    // time-state generator
    time_state_gen u_tsg (
        .clk(clk),
        .rst(rst),
        .runEn(s.run),
        .slowCycle(slowCycle),
        .timeState_n(timeState_n),
        .timePulse(timePulse),
        .idle(idle)
    );

    // =========================================================
    // decode of the held instruction and of the bus state
    assign ts = ~timeState_n;
    assign opc = s.ir[11:9];
    assign isOpr2 = (s.ir[11:8] == `OPR_GROUP) && !s.ir[0];
    assign isOpr3 = (s.ir[11:8] == `OPR_GROUP) && s.ir[0];
    assign prot = !protectedMode_n;
    assign switchRd = isOpr2 && s.ir[2];
    assign haltInstr = isOpr2 && s.ir[1] && !prot;
    assign disc = !stateRegDisconnect_n;
    assign dmaState = disc && (&majorBus_n);
    assign effAddr = {s.ir[7] ? s.ma[11:7] : 5'h00, s.ir[6:0]};
    assign keyAny = fieldLoadKey || examineKey || depositKey;

    // next major state and next program counter
    always_comb begin
        nextMajor = FETCH;
        pcNext = s.pc;
        unique case (s.major)
            FETCH: begin
                if (opc <= `OPC_JMP) begin
                    if (s.ir[8]) begin
                        nextMajor = DEFER;
                    end else if (opc == `OPC_JMP) begin
                        pcNext = effAddr;
                    end else begin
                        nextMajor = EXECUTE;
                    end
                end
            end
            DEFER: begin
                if (opc == `OPC_JMP) begin
                    pcNext = memData;
                end else begin
                    nextMajor = EXECUTE;
                end
            end
            EXECUTE: begin
                // an overlay hit saves the return slot by running from the address itself
                if (opc == `OPC_JMS) begin
                    pcNext = romAddrSel_n ? s.ma + 12'h001 : s.ma;
                end
            end
            default: begin
                nextMajor = FETCH;
            end
        endcase
    end

    assign nextFetch = (nextMajor == FETCH) || dmaState;
    // halt key only bites on an instruction boundary
    assign haltReq = (haltKey && nextFetch) || singleStepKey || s.keyGate
        || (haltInstr && s.major == FETCH);

    // =========================================================
    // register update
    always_comb begin
        next_s = s;
        next_s.powerPrev = powerOk;
        next_s.keyPrev = keyAny;
        // run flip-flop: power loss also counts as a stop request
        if (timePulse[2] && (haltReq || !powerOk)) begin
            next_s.run = 1'b0;
        end
        if (!memStart_n && powerOk) begin
            next_s.run = 1'b1;
        end
        // key gate: a fresh press wins over the release at pulse four
        if (timePulse[3]) begin
            next_s.keyGate = 1'b0;
        end
        if (keyAny && !s.keyPrev) begin
            next_s.keyGate = 1'b1;
        end
        // pulse two: instruction capture and carry out of the buffer
        if (timePulse[1] && !dmaState) begin
            next_s.carryFF = (s.major == EXECUTE) && (opc == `OPC_ISZ) && (&memData);
            if (s.major == FETCH) begin
                next_s.ir = memData;
                next_s.pc = s.pc + 12'h001;
            end
        end
        // pulse three: I/O dialogue and operate groups in fetch
        if (timePulse[2] && s.major == FETCH && !dmaState) begin
            if (opc == `OPC_IOT && !prot) begin
                next_s.ac = s.ac | dataIn;
                if (s.ir == `IOT_ION) begin
                    next_s.intEn = 1'b1;
                end
                if (s.ir == `IOT_IOF) begin
                    next_s.intEn = 1'b0;
                end
                if (s.ir == `IOT_CLEAR) begin
                    next_s.sysCnt = 4'(`SYSCLR_CYC);
                end
            end
            if (switchRd && !prot) begin
                next_s.ac = s.ac | switchReg;
            end
            if (isOpr3 && s.ir[4]) begin
                next_s.mq = s.ac;
                next_s.ac = 12'h000;
            end
        end
        // pulse four: address register and major state advance
        if (timePulse[3] && !dmaState) begin
            if (s.keyGate) begin
                next_s.pc = s.ma + 12'h001;
            end else begin
                next_s.pc = pcNext;
                next_s.major = nextMajor;
                if (nextMajor == FETCH) begin
                    next_s.ma = pcNext;
                end else if (s.major == FETCH) begin
                    next_s.ma = effAddr;
                end else begin
                    next_s.ma = memData;
                end
                if (s.major == EXECUTE && (opc == `OPC_JMS || opc == `OPC_JMP)) begin
                    next_s.ifld = s.ib;
                end
            end
            next_s.driveInh = !powerOk;
        end else if (powerOk && idle && !s.run) begin
            next_s.driveInh = 1'b0;
        end
        // panel address load, never starts a cycle
        if (panelAddrLoadPulse) begin
            if (s.keyGate) begin
                next_s.ib = dataIn[5:3];
                next_s.ifld = dataIn[5:3];
                next_s.df = dataIn[2:0];
            end else begin
                next_s.ma = dataIn;
            end
        end
        // system clear: counter keeps the pulse wide enough
        if (s.sysCnt != 4'h0) begin
            next_s.sysCnt = s.sysCnt - 4'h1;
        end
        if ((s.powerPrev && !powerOk) || clearKey) begin
            next_s.sysCnt = 4'(`SYSCLR_CYC);
        end
        if (s.sysCnt != 4'h0) begin
            next_s.ac = 12'h000;
            next_s.link = 1'b0;
        end
        // carry jam loads every cycle the line is held
        if (!carryLoad_n) begin
            next_s.link = !carryIn_n;
        end
        // return current lags the drive by a counted tail
        if (ramOn) begin
            next_s.retCnt = 2'(`RET_LAG_CYC);
        end else if (s.retCnt != 2'h0) begin
            next_s.retCnt = s.retCnt - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // =========================================================
    // memory timing; drive stays off after a power-fail cycle
    assign cycOn = s.run || !idle;
    assign ramOn = cycOn && !s.driveInh && romAddrSel_n;
    assign driveCur = ramOn;
    assign memWrite = ramOn && (ts[2] || ts[3]);
    assign inhibitDrive = memWrite;
    assign returnCur = ramOn || (s.retCnt != 2'h0);
    // strobe drops when pulse two rises, where the instruction is taken
    assign senseStrobe = ramOn && ts[1] && !timePulse[1];

    // =========================================================
    // state lines released while a break device disconnects them
    assign opcodeLines_n = disc ? 3'h7 : ~opc;
    assign fetchLine_n = disc || (s.major != FETCH);
    assign deferLine_n = disc || (s.major != DEFER);
    assign executeLine_n = disc || (s.major != EXECUTE);

    // =========================================================
    // panel and status outputs
    assign carryLine_n = !s.link;
    assign carryOutLine_n = !(s.carryFF && ts[2]);
    assign keyGate_n = !s.keyGate;
    assign intInhibit = s.keyGate;
    assign haltRequest_n = !haltReq;
    assign runLine_n = !s.run;
    assign sysClear = (s.sysCnt != 4'h0);

    always_comb begin
        statusWord = 12'h000;
        statusWord[`ST_LINK] = s.link;
        statusWord[`ST_GT] = greaterThanFlag;
        statusWord[`ST_INTBUS] = intBus;
        statusWord[`ST_NOINT] = s.keyGate;
        statusWord[`ST_INTEN] = s.intEn;
        statusWord[`ST_PROT] = prot;
        statusWord[`ST_IF_HI:`ST_IF_LO] = s.ifld;
        statusWord[`ST_DF_HI:`ST_DF_LO] = s.df;
    end

    // bus mux; low-high select leaves the bus to the panel
    always_comb begin
        dataOut = 12'h000;
        dataOe_n = 1'b1;
        if (ts[0] && !(displaySelB && !displaySelA)) begin
            dataOe_n = 1'b0;
            if (displaySelA && displaySelB) begin
                dataOut = statusWord;
            end else if (displaySelA) begin
                dataOut = s.mq;
            end else begin
                dataOut = s.ac;
            end
        end else if (ts[2] && s.major == FETCH && switchRd && !prot) begin
            dataOe_n = 1'b0;
            dataOut = switchReg;
        end
    end

    // =========================================================
    // checks
    sequence sRetTail;
        returnCur ##1 !returnCur;
    endsequence

    sequence sClearHeld;
        sysClear [*6];
    endsequence

    a_return_tail: assert property ($fell(driveCur) && romAddrSel_n |-> sRetTail)
        else $error("return current tail wrong");
    a_return_rise: assert property ($rose(driveCur) |-> returnCur)
        else $error("return current not with drive");
    a_clear_width: assert property ($rose(sysClear) |-> sClearHeld)
        else $error("system clear too short");
    a_clear_acc: assert property (sysClear |=> s.ac == 12'h000)
        else $error("clear left accumulator set");
    a_run_stop: assert property (timePulse[2] && haltReq && memStart_n |=> runLine_n)
        else $error("run not cleared on halt");
    a_run_start: assert property (!memStart_n && powerOk |=> !runLine_n)
        else $error("run not set by memory start");
    a_state_single: assert property (stateRegDisconnect_n |->
        $onehot({!fetchLine_n, !deferLine_n, !executeLine_n}))
        else $error("major state lines not one-hot");
    a_dma_fetch: assert property (dmaState |-> nextFetch)
        else $error("dma state without next fetch");
    a_carry_load: assert property (!carryLoad_n |=> carryLine_n == $past(carryIn_n))
        else $error("carry not jam loaded");
    a_carry_gate: assert property (!carryOutLine_n |-> !timeState_n[2])
        else $error("carry out outside state three");
    a_key_hold: assert property (s.keyGate && timePulse[3] && !panelAddrLoadPulse
        |=> $stable(s.ma) && s.pc == $past(s.ma) + 12'h001)
        else $error("key gate did not hold address");
    a_gate_drop: assert property (timePulse[3] && !(keyAny && !s.keyPrev) |=> keyGate_n)
        else $error("key gate not released");
    a_prot_bus: assert property (prot && ts[2] |-> dataOe_n)
        else $error("switches reached bus in protected mode");
    a_state_len: assert property ($fell(timeState_n[1]) |-> !timeState_n[1] [*2])
        else $error("time state too short");
    a_pulse_width: assert property (timePulse[0] |=> !timePulse[0])
        else $error("time pulse too wide");
    a_overlay_idle: assert property (!romAddrSel_n |-> !driveCur && !memWrite)
        else $error("memory driven during overlay");
endmodule
`default_nettype wire

// ### mem_model.sv
// memory module model: serves a read word and answers the overlay line
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    // clock
    input wire logic clk,
    // memory timing from the processor
    input wire logic driveCur,
    // word to serve and overlay hit request
    input wire logic [11:0] word,
    input wire logic romHit,
    // lines to the processor
    output logic [11:0] memData,
    output logic romAddrSel_n
);
    // ==========================================================
    // read data
    logic [11:0] junk = 12'h0a5c;
    // outside a drive window the lines toggle, so stale data never looks valid
    always @(posedge clk) begin
        junk <= ~junk;
    end
    // data is held through the whole drive window, so it is valid at the strobe fall
    assign memData = driveCur ? word : junk;
    // overlay memory grounds the line as soon as it sees its own address
    assign romAddrSel_n = !romHit;
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the processor control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cpu_ctl_pkg::*;
    // ==========================================================
    // signals
    logic clk, rst, memStart_n, slowCycle, powerOk, romAddrSel_n, romHit;
    logic [11:0] memData, word, switchReg, dataIn, dataOut, r;
    logic memWrite, driveCur, returnCur, inhibitDrive, senseStrobe, dmaState, nextFetch;
    logic [2:0] opcodeLines_n, majorBus_n, extGnd_n;
    logic fetchLine_n, deferLine_n, executeLine_n, stateRegDisconnect_n;
    logic carryLoad_n, carryIn_n, carryLine_n, carryOutLine_n, lnk, drvPrev;
    logic fieldLoadKey, examineKey, depositKey, haltKey, singleStepKey, clearKey;
    logic panelAddrLoadPulse, displaySelA, displaySelB, keyGate_n, haltRequest_n;
    logic runLine_n, dataOe_n, greaterThanFlag, intBus, protectedMode_n;
    logic intInhibit, sysClear;
    logic [3:0] timeState_n, timePulse;
    int fails = 0;
    int numChecks = 0;
    int gap = 0;
    int n;
    int seed = 32'h1756;
    int pq[$];
    // external devices may ground the state lines on the wired bus
    assign majorBus_n = {executeLine_n, deferLine_n, fetchLine_n} & extGnd_n;
    cpu_ctl DUT (.*);
    mem_model mem (.clk(clk), .driveCur(driveCur), .word(word), .romHit(romHit),
        .memData(memData), .romAddrSel_n(romAddrSel_n));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // ==========================================================
    // tasks
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        numChecks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // inputs always move a fixed 10 ns after the rising edge
    task automatic tick(input int k = 1);
        repeat (k) @(posedge clk);
        #10;
    endtask
    task automatic completeRun();
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one single-stepped memory cycle; the watcher consumes the noted pulses
    task automatic oneCycle(input logic slow);
        int g;
        tick(); // lets the return tail of the last cycle run out before drive rises again
        g = slow ? 3 : 2;
        slowCycle = slow;
        singleStepKey = 1;
        for (int k = 0; k < 4; k++) pq.push_back(k + 4 * (k > 0 ? g : 0));
        memStart_n = 0;
        tick();
        memStart_n = 1;
        for (int i = 0; i < 40 && (runLine_n !== 1'b1 || pq.size() != 0); i++) tick();
        singleStepKey = 0;
        chk("stopped", 4'b1110, timeState_n);
        chk("run", 1, runLine_n);
    endtask
    task automatic sweep(output int c);
        c = 0;
        repeat (20) begin
            if (sysClear === 1'b1) c++;
            tick();
        end
    endtask
    // walk all four display selections while stopped in state one
    task automatic show(input logic gt8, input logic [5:0] f);
        logic [11:0] st;
        greaterThanFlag = $random(seed);
        intBus = $random(seed);
        protectedMode_n = $random(seed);
        st = {lnk, greaterThanFlag, intBus, gt8, 1'b0, !protectedMode_n, f};
        for (int s = 0; s < 4; s++) begin
            {displaySelA, displaySelB} = s[1:0];
            tick();
            chk("oe", s == 1, dataOe_n);
            if (s != 1) chk("bus", s == 3 ? st : 12'h0, dataOut);
        end
        $display("test display done");
    endtask
    // ==========================================================
    // watcher: compares each time pulse against the oldest note
    always @(posedge clk) begin
        int e;
        if (!rst) begin
            if (stateRegDisconnect_n) chk("onelow", 1, $countones(~{fetchLine_n, deferLine_n, executeLine_n}));
            if (!romAddrSel_n) chk("overlay", 0, {memWrite, driveCur, senseStrobe});
            if (drvPrev && !driveCur) chk("return", 1, returnCur);
            chk("write", 0, memWrite & timeState_n[2] & timeState_n[3]);
            chk("carryout", 1, carryOutLine_n | !timeState_n[2]);
            if (!timeState_n[1]) chk("strobe", romAddrSel_n && !timePulse[1], senseStrobe);
            if (timePulse !== 4'h0) begin
                if (pq.size() == 0) chk("pulse", 0, timePulse);
                else begin
                    e = pq.pop_front();
                    chk("pulse", 12'h1 << e % 4, timePulse);
                    chk("state", 4'(~(4'h1 << e % 4)), timeState_n);
                    chk("drive", {2{romAddrSel_n}}, {driveCur, returnCur});
                    chk("wrinh", {2{romAddrSel_n && e % 4 > 1}}, {memWrite, inhibitDrive});
                    if (e > 3) chk("gap", e / 4, gap);
                end
                gap = 1;
            end else gap++;
        end
        drvPrev = driveCur;
    end
    // a hang is cut short and counted as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        completeRun();
    end
    // ==========================================================
    // main sequence
    initial begin
        {rst, memStart_n, powerOk, carryLoad_n, carryIn_n, stateRegDisconnect_n} = 6'h3f;
        {fieldLoadKey, examineKey, depositKey, haltKey, singleStepKey, clearKey} = 6'h0;
        {panelAddrLoadPulse, displaySelA, displaySelB, romHit, slowCycle} = 5'h0;
        {greaterThanFlag, intBus, protectedMode_n, lnk} = 4'h1;
        extGnd_n = 3'b111;
        word = 12'h0000;
        dataIn = 12'h0000;
        switchReg = $random(seed);
        repeat (16) @(posedge clk);
        #10;
        rst = 0;
        chk("rst state", 4'b1110, timeState_n);
        chk("rst run", 1, runLine_n);
        chk("rst gate", 1, keyGate_n);
        chk("rst clear", 0, sysClear);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            word = {3'(r % 6), 1'b0, r[7:0]};
            oneCycle(i[0]);
            chk("opc", 3'(~word[11:9]), opcodeLines_n);
            if (word[11:9] != 3'h5) oneCycle(0);
        end
        $display("test cycles done");
        for (int i = 0; i < 5; i++) begin
            carryIn_n = i < 4 ? 1'($random(seed)) : 1'b0;
            carryLoad_n = 0;
            tick();
            carryLoad_n = 1;
            chk("carry", carryIn_n, carryLine_n);
        end
        clearKey = 1;
        tick();
        clearKey = 0;
        sweep(n);
        chk("clear len", 6, n);
        chk("clear link", 1, carryLine_n);
        powerOk = 0;
        sweep(n);
        chk("power len", 6, n);
        memStart_n = 0;
        tick(3);
        chk("refused", 1, runLine_n);
        memStart_n = 1;
        powerOk = 1;
        tick();
        lnk = 0;
        $display("test clear done");
        show(0, 6'h00);
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            {fieldLoadKey, examineKey, depositKey} = 3'b100 >> k;
            tick(2);
            chk("gate", 0, keyGate_n);
            chk("inhibit", 1, intInhibit);
            chk("haltreq", 0, haltRequest_n);
            dataIn = r;
            panelAddrLoadPulse = 1;
            tick();
            panelAddrLoadPulse = 0;
            show(1, r[5:0]);
            {fieldLoadKey, examineKey, depositKey} = 3'b000;
            oneCycle(k[0]);
            chk("release", 1, keyGate_n);
        end
        // the clear instruction only bites outside protected mode
        word = 12'hc07;
        for (int p = 0; p < 2; p++) begin
            protectedMode_n = p[0];
            oneCycle(0);
            chk("io clear", p, sysClear);
        end
        romHit = 1;
        oneCycle(0);
        romHit = 0;
        stateRegDisconnect_n = 0;
        tick();
        chk("dma", 1, dmaState);
        chk("nextfetch", 1, nextFetch);
        chk("opc off", 3'b111, opcodeLines_n);
        extGnd_n = 3'b110;
        tick();
        chk("dma grounded", 0, dmaState);
        extGnd_n = 3'b111;
        stateRegDisconnect_n = 1;
        tick();
        $display("test panel and dma done");
        completeRun();
    end
endmodule
`default_nettype wire
